// ===== tcc_pkg.sv
// Package of constants and types for the temperature and RTC compensation block
package tcc_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int COEF_W  = 16;
	localparam int TEMP_W  = 16;
	localparam int GAIN_W  = 16;
	localparam int PHASE_W = 16;
	localparam int ACC_W   = 40;
	localparam int PPB_W   = 40;

	// ----------------------------------------
	// Reset and default values
	// ----------------------------------------
	localparam logic [COEF_W-1:0]  COEF_ZERO        = 16'h0000;
	localparam logic [TEMP_W-1:0]  TEMP_ZERO        = 16'h0000;
	localparam logic [GAIN_W-1:0]  GAIN_NOMINAL     = 16'h4000;
	localparam logic [PHASE_W-1:0] PHASE_CT_DEFAULT = 16'h0000;
	localparam logic [1:0]         SENSOR_ROGOWSKI  = 2'h1;

	// ----------------------------------------
	// RTC correction scaling
	// ----------------------------------------
	// Correction is carried in units of 1/1000 ppm so all three terms stay integer
	localparam logic [ACC_W-1:0] OFFSET_MUL    = 40'h0000000064;
	localparam logic [ACC_W-1:0] SKEW_MUL      = 40'h000000000A;
	localparam logic [ACC_W-1:0] STEP_THRESH   = 40'h003B9ACA00;
	localparam int               SECOND_NS     = 1000000000;
	localparam int               CLK_PERIOD_NS = 8;
	localparam int               SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;

	// ----------------------------------------
	// Phase identifiers
	// ----------------------------------------
	typedef enum logic [1:0] {
		PH_A,
		PH_B,
		PH_C
	} tcc_phase_type;
endpackage

// ===== tcc_core.sv
// Temperature drift, RTC trim and per-phase calibration factor store
//
// Summary of operation
// [R1] Select bit chooses internal or host coefficients
// [R2] Nominal temperature and coefficients zero after reset
// [R3] Nominal write with select loads stored coefficients
// [R4] Auto load only while both coefficients zero
// [R5] Coefficients held zero until nominal loaded
// [R6] Zero nominal temperature disables compensation
// [R7] Host merges own correction, keeps select zero
// [R8] RTC trimmed by one-second steps only
// [R9] Positive correction advances clock faster
// [R10] Ppm is offset/10 plus skew, stability terms
// [R11] Gain factor scales channel gain linearly
// [R12] Rogowski mode adds three feedthrough factors
// [R13] Rogowski mode gives nonzero phase defaults
// [R14] Host restores gain, phase, nominal after power-up
// [R15] Temperature sampled once per accumulation interval
// [R16] All register bits cleared during reset except channel gain factors, which load GAIN_NOMINAL
// [R17] Accumulate ppm each second, step at million
`timescale 1ns/1ns
module tcc_core #(
	parameter int                          SECOND_CYCLES   = tcc_pkg::SECOND_CYCLES,
	parameter logic [tcc_pkg::COEF_W-1:0]  REF_LINEAR      = 16'h0100,
	parameter logic [tcc_pkg::COEF_W-1:0]  REF_QUADRATIC   = 16'h0010,
	parameter logic [tcc_pkg::PHASE_W-1:0] PHASE_ROG_DEF   = 16'h0800
) (
	input  wire logic                          CLK_IN,
	input  wire logic                          RST_IN,
	input  wire logic                          INTERNAL_COMP_SELECT_IN,
	input  wire logic [1:0]                    SENSOR_TYPE_FIELD_IN,
	input  wire logic                          NOMINAL_TEMP_WR_IN,
	input  wire logic [tcc_pkg::TEMP_W-1:0]    NOMINAL_TEMP_VALUE_IN,
	input  wire logic                          COEFF_WR_IN,
	input  wire logic [tcc_pkg::COEF_W-1:0]    LINEAR_DRIFT_COEFF_IN,
	input  wire logic [tcc_pkg::COEF_W-1:0]    QUADRATIC_DRIFT_COEFF_IN,
	input  wire logic                          TEMP_SAMPLE_IN,
	input  wire logic [tcc_pkg::TEMP_W-1:0]    TEMP_RAW_IN,
	input  wire logic                          RTC_TERMS_WR_IN,
	input  wire logic [15:0]                   RTC_OFFSET_TERM_IN,
	input  wire logic [15:0]                   RTC_SKEW_TERM_IN,
	input  wire logic [15:0]                   RTC_STABILITY_TERM_IN,
	input  wire logic                          CAL_WR_IN,
	input  wire logic [1:0]                    CAL_PHASE_IN,
	input  wire logic [tcc_pkg::GAIN_W-1:0]    CHANNEL_GAIN_FACTOR_I_IN,
	input  wire logic [tcc_pkg::GAIN_W-1:0]    CHANNEL_GAIN_FACTOR_V_IN,
	input  wire logic [tcc_pkg::PHASE_W-1:0]   PHASE_COMP_FACTOR_IN,
	input  wire logic [tcc_pkg::PHASE_W-1:0]   FEEDTHROUGH_COMP_FACTOR_IN,
	input  wire logic [1:0]                    CAL_RD_PHASE_IN,
	input  wire logic [23:0]                   CHANNEL_SAMPLE_IN,
	input  wire logic [1:0]                    CHANNEL_SEL_IN,
	output logic      [tcc_pkg::TEMP_W-1:0]    NOMINAL_TEMP_VALUE_OUT,
	output logic      [tcc_pkg::COEF_W-1:0]    LINEAR_DRIFT_COEFF_OUT,
	output logic      [tcc_pkg::COEF_W-1:0]    QUADRATIC_DRIFT_COEFF_OUT,
	output logic                               COMP_ACTIVE_OUT,
	output logic      [tcc_pkg::TEMP_W-1:0]    TEMP_DELTA_OUT,
	output logic      [tcc_pkg::GAIN_W-1:0]    CHANNEL_GAIN_FACTOR_I_OUT,
	output logic      [tcc_pkg::GAIN_W-1:0]    CHANNEL_GAIN_FACTOR_V_OUT,
	output logic      [tcc_pkg::PHASE_W-1:0]   PHASE_COMP_FACTOR_OUT,
	output logic      [tcc_pkg::PHASE_W-1:0]   FEEDTHROUGH_COMP_FACTOR_OUT,
	output logic      [39:0]                   SCALED_SAMPLE_OUT,
	output logic                               RTC_STEP_FWD_OUT,
	output logic                               RTC_STEP_BACK_OUT
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [tcc_pkg::TEMP_W-1:0]    nom;
		logic                          nom_loaded;
		logic [tcc_pkg::COEF_W-1:0]    lin;
		logic [tcc_pkg::COEF_W-1:0]    quad;
		logic [tcc_pkg::TEMP_W-1:0]    temp;
		logic [15:0]                   offs;
		logic [15:0]                   skew;
		logic [15:0]                   stab;
		logic [2:0][tcc_pkg::GAIN_W-1:0]  gain_i;
		logic [2:0][tcc_pkg::GAIN_W-1:0]  gain_v;
		logic [2:0][tcc_pkg::PHASE_W-1:0] phase;
		logic [2:0]                       phase_wr;
		logic [2:0][tcc_pkg::PHASE_W-1:0] feed;
		logic [31:0]                   sec_cnt;
		logic signed [tcc_pkg::ACC_W-1:0] acc;
		logic                          step_fwd;
		logic                          step_back;
		logic [39:0]                   scaled;
	} tcc_state_type;

	tcc_state_type st_r;
	tcc_state_type st_nxt;

	// ----------------------------------------
	// Working signals
	// ----------------------------------------
	logic                                  rogowski;
	logic signed [tcc_pkg::TEMP_W:0]       delta;
	logic signed [tcc_pkg::ACC_W-1:0]      delta_ext;
	logic signed [tcc_pkg::ACC_W-1:0]      offs_ext;
	logic signed [tcc_pkg::ACC_W-1:0]      skew_ext;
	logic signed [tcc_pkg::ACC_W-1:0]      stab_ext;
	logic signed [tcc_pkg::ACC_W-1:0]      offs_part;
	logic signed [tcc_pkg::ACC_W-1:0]      skew_part;
	logic signed [tcc_pkg::ACC_W-1:0]      stab_part;
	logic signed [tcc_pkg::ACC_W-1:0]      ppm_milli;
	logic signed [tcc_pkg::ACC_W-1:0]      acc_sum;
	logic [1:0]                            ph;
	logic [15:0]                           gain_sel;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Decodes a phase index, folding the unused code onto phase C
	function automatic logic [1:0] tcc_phase_idx(input logic [1:0] code);
		tcc_phase_idx = (code > 2'h2) ? 2'h2 : code;
	endfunction

	// Sign-extends a 16-bit correction term to accumulator width
	function automatic logic signed [tcc_pkg::ACC_W-1:0] tcc_sext16(input logic [15:0] v);
		tcc_sext16 = {{(tcc_pkg::ACC_W-16){v[15]}}, v};
	endfunction

	// ----------------------------------------
	// Combinational next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		// [R12] Rogowski sensor select
		rogowski = (SENSOR_TYPE_FIELD_IN == tcc_pkg::SENSOR_ROGOWSKI);
		// ----------------------------------------
		// RTC correction terms
		// ----------------------------------------
		// Raw temperatures are unsigned, so widen by one bit before the signed difference
		delta = $signed({1'b0, st_r.temp}) - $signed({1'b0, st_r.nom});
		delta_ext = {{(tcc_pkg::ACC_W-tcc_pkg::TEMP_W-1){delta[tcc_pkg::TEMP_W]}}, delta};
		offs_ext = tcc_sext16(st_r.offs);
		skew_ext = tcc_sext16(st_r.skew);
		stab_ext = tcc_sext16(st_r.stab);
		// [R10] Correction in milli-ppm
		offs_part = offs_ext * $signed(tcc_pkg::OFFSET_MUL);
		skew_part = skew_ext * $signed(tcc_pkg::SKEW_MUL) * delta_ext;
		// Stability term already carries the 1/1000 scale, so no multiplier here
		stab_part = stab_ext * delta_ext * delta_ext;
		ppm_milli = offs_part + skew_part + stab_part;
		// Only one step is taken per second; a correction above one second per
		// second leaves a growing residue, which the unsaturated 40-bit sum wraps once it overflows
		acc_sum = st_r.acc + ppm_milli;

		// ----------------------------------------
		// Phase selects
		// ----------------------------------------
		ph = tcc_phase_idx(CAL_PHASE_IN);
		gain_sel = CHANNEL_SEL_IN[0] ? st_r.gain_v[tcc_phase_idx(CHANNEL_SEL_IN)]
			: st_r.gain_i[tcc_phase_idx(CHANNEL_SEL_IN)];

		// ----------------------------------------
		// Drift coefficient store
		// ----------------------------------------
		// Nominal write wins over a host coefficient write in the same cycle
		// [R3] Auto load on nominal write
		if (NOMINAL_TEMP_WR_IN) begin
			st_nxt.nom = NOMINAL_TEMP_VALUE_IN;
			st_nxt.nom_loaded = 1'b1;
			// [R4] Only when both zero
			if (INTERNAL_COMP_SELECT_IN && st_r.lin == tcc_pkg::COEF_ZERO
				&& st_r.quad == tcc_pkg::COEF_ZERO) begin
				st_nxt.lin = REF_LINEAR;
				st_nxt.quad = REF_QUADRATIC;
			end
		// [R1] Host coefficients when select clear
		end else if (COEFF_WR_IN && !INTERNAL_COMP_SELECT_IN && st_r.nom_loaded) begin
			st_nxt.lin = LINEAR_DRIFT_COEFF_IN;
			st_nxt.quad = QUADRATIC_DRIFT_COEFF_IN;
		end
		// [R5] Held zero before nominal
		if (!st_r.nom_loaded && !NOMINAL_TEMP_WR_IN) begin
			st_nxt.lin = tcc_pkg::COEF_ZERO;
			st_nxt.quad = tcc_pkg::COEF_ZERO;
		end

		// ----------------------------------------
		// Temperature and RTC terms
		// ----------------------------------------
		// [R15] One sample per interval
		if (TEMP_SAMPLE_IN) begin
			st_nxt.temp = TEMP_RAW_IN;
		end
		if (RTC_TERMS_WR_IN) begin
			st_nxt.offs = RTC_OFFSET_TERM_IN;
			st_nxt.skew = RTC_SKEW_TERM_IN;
			st_nxt.stab = RTC_STABILITY_TERM_IN;
		end

		// ----------------------------------------
		// Per-phase calibration factors
		// ----------------------------------------
		// Written flag lets the phase default follow the sensor type until a write
		if (CAL_WR_IN) begin
			st_nxt.gain_i[ph] = CHANNEL_GAIN_FACTOR_I_IN;
			st_nxt.gain_v[ph] = CHANNEL_GAIN_FACTOR_V_IN;
			st_nxt.phase[ph] = PHASE_COMP_FACTOR_IN;
			st_nxt.phase_wr[ph] = 1'b1;
			st_nxt.feed[ph] = FEEDTHROUGH_COMP_FACTOR_IN;
		end

		// ----------------------------------------
		// Sample scaling
		// ----------------------------------------
		// Low 40 bits only; the unity gain code keeps typical samples in range
		// [R11] Linear gain scaling
		st_nxt.scaled = {{16{CHANNEL_SAMPLE_IN[23]}}, CHANNEL_SAMPLE_IN}
			* {24'h000000, gain_sel};

		// ----------------------------------------
		// Second counter and step
		// ----------------------------------------
		// Steps are one-cycle pulses; the counter is never stopped or trimmed
		// [R17] Per-second accumulation and step
		st_nxt.step_fwd = 1'b0;
		st_nxt.step_back = 1'b0;
		if (st_r.sec_cnt >= 32'(SECOND_CYCLES - 1)) begin
			st_nxt.sec_cnt = 32'h00000000;
			// [R8] Whole-second steps, oscillator untouched
			if (acc_sum >= $signed(tcc_pkg::STEP_THRESH)) begin
				// [R9] Positive runs faster
				st_nxt.step_fwd = 1'b1;
				st_nxt.acc = acc_sum - $signed(tcc_pkg::STEP_THRESH);
			end else if (acc_sum <= -$signed(tcc_pkg::STEP_THRESH)) begin
				st_nxt.step_back = 1'b1;
				st_nxt.acc = acc_sum + $signed(tcc_pkg::STEP_THRESH);
			end else begin
				st_nxt.acc = acc_sum;
			end
		end else begin
			st_nxt.sec_cnt = st_r.sec_cnt + 32'h00000001;
		end
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge CLK_IN) begin
		// [R16] Clear all bits in reset, then load GAIN_NOMINAL into every channel gain factor
		if (RST_IN) begin
			// [R2] Zero after power-up
			st_r <= '0;
			for (int i = 0; i < 3; i++) begin
				st_r.gain_i[i] <= tcc_pkg::GAIN_NOMINAL;
				st_r.gain_v[i] <= tcc_pkg::GAIN_NOMINAL;
			end
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Readback phase select is combinational so the host sees a new phase at once
	logic [1:0] rp;
	assign rp = tcc_phase_idx(CAL_RD_PHASE_IN);

	// ----------------------------------------
	// Stored values
	// ----------------------------------------
	assign NOMINAL_TEMP_VALUE_OUT = st_r.nom;
	assign LINEAR_DRIFT_COEFF_OUT = st_r.lin;
	assign QUADRATIC_DRIFT_COEFF_OUT = st_r.quad;
	// [R6] No compensation at zero nominal
	assign COMP_ACTIVE_OUT = (st_r.nom != tcc_pkg::TEMP_ZERO) && st_r.nom_loaded;
	assign TEMP_DELTA_OUT = st_r.temp - st_r.nom;

	// ----------------------------------------
	// Phase readback
	// ----------------------------------------
	assign CHANNEL_GAIN_FACTOR_I_OUT = st_r.gain_i[rp];
	assign CHANNEL_GAIN_FACTOR_V_OUT = st_r.gain_v[rp];
	// [R13] Rogowski phase default until written
	assign PHASE_COMP_FACTOR_OUT = st_r.phase_wr[rp] ? st_r.phase[rp]
		: (rogowski ? PHASE_ROG_DEF : tcc_pkg::PHASE_CT_DEFAULT);
	// [R12] Feedthrough only in Rogowski mode
	assign FEEDTHROUGH_COMP_FACTOR_OUT = rogowski ? st_r.feed[rp] : 16'h0000;

	// ----------------------------------------
	// Sample and RTC step outputs
	// ----------------------------------------
	assign SCALED_SAMPLE_OUT = st_r.scaled;
	assign RTC_STEP_FWD_OUT = st_r.step_fwd;
	assign RTC_STEP_BACK_OUT = st_r.step_back;
endmodule

// ===== tcc_core_assertions.sv
// Assertion checker for the compensation coefficient store
`timescale 1ns/1ns
module tcc_core_assertions #(
	parameter logic [15:0] REF_LINEAR    = 16'h0100,
	parameter logic [15:0] REF_QUADRATIC = 16'h0010
) (
	input wire logic        CLK_IN, RST_IN, INTERNAL_COMP_SELECT_IN, NOMINAL_TEMP_WR_IN,
	input wire logic        COEFF_WR_IN, COMP_ACTIVE_OUT, RTC_STEP_FWD_OUT, RTC_STEP_BACK_OUT,
	input wire logic [1:0]  SENSOR_TYPE_FIELD_IN,
	input wire logic [15:0] NOMINAL_TEMP_VALUE_OUT, LINEAR_DRIFT_COEFF_OUT,
	input wire logic [15:0] QUADRATIC_DRIFT_COEFF_OUT, FEEDTHROUGH_COMP_FACTOR_OUT
);
	// ----------------------------------------
	// Helper state
	// ----------------------------------------
	logic        loaded_r;
	logic        loaded_nxt;
	wire  [31:0] coefs = {LINEAR_DRIFT_COEFF_OUT, QUADRATIC_DRIFT_COEFF_OUT};
	always_comb loaded_nxt = loaded_r | NOMINAL_TEMP_WR_IN;
	always_ff @(posedge CLK_IN) loaded_r <= RST_IN ? 1'b0 : loaded_nxt;
	default clocking @(posedge CLK_IN); endclocking
	default disable iff (RST_IN);
	sequence nom_wr_s; NOMINAL_TEMP_WR_IN; endsequence
	sequence auto_ok_s; INTERNAL_COMP_SELECT_IN && coefs == 32'h0; endsequence
	reset_clear_a: assert property (disable iff (1'b0) RST_IN |=>
		NOMINAL_TEMP_VALUE_OUT == 16'h0000 && coefs == 32'h0) else $error("not cleared");
	auto_load_a: assert property (nom_wr_s ##0 auto_ok_s |=>
		coefs == {REF_LINEAR, REF_QUADRATIC}) else $error("no auto load");
	no_reload_a: assert property (nom_wr_s ##0 coefs != 32'h0 |=> $stable(coefs))
		else $error("coefficients reloaded");
	host_refuse_a: assert property (COEFF_WR_IN && INTERNAL_COMP_SELECT_IN &&
		!NOMINAL_TEMP_WR_IN |=> $stable(coefs)) else $error("host write taken");
	coef_hold_a: assert property (!loaded_r |-> coefs == 32'h0)
		else $error("coefficients before nominal");
	comp_off_a: assert property (NOMINAL_TEMP_VALUE_OUT == 16'h0000 |-> !COMP_ACTIVE_OUT)
		else $error("active at zero nominal");
	feed_zero_a: assert property (SENSOR_TYPE_FIELD_IN != 2'h1 &&
		$past(SENSOR_TYPE_FIELD_IN) != 2'h1 |-> FEEDTHROUGH_COMP_FACTOR_OUT == 16'h0000)
		else $error("feedthrough outside coil mode");
	step_pulse_a: assert property (RTC_STEP_FWD_OUT || RTC_STEP_BACK_OUT |->
		!(RTC_STEP_FWD_OUT && RTC_STEP_BACK_OUT) ##1 !(RTC_STEP_FWD_OUT || RTC_STEP_BACK_OUT))
		else $error("bad step pulse");
endmodule
bind tcc_core tcc_core_assertions #(.REF_LINEAR(REF_LINEAR), .REF_QUADRATIC(REF_QUADRATIC)) u_chk (.*);

// ===== tcc_host_model.sv
// Host processor model driving the calibration write inputs
`timescale 1ns/1ns
module tcc_host_model (
	input  wire logic  CLK_IN,
	output logic       INTERNAL_COMP_SELECT_IN, NOMINAL_TEMP_WR_IN, COEFF_WR_IN,
	output logic       TEMP_SAMPLE_IN, RTC_TERMS_WR_IN, CAL_WR_IN,
	output logic [1:0] SENSOR_TYPE_FIELD_IN, CAL_PHASE_IN,
	output logic [15:0] NOMINAL_TEMP_VALUE_IN, LINEAR_DRIFT_COEFF_IN, QUADRATIC_DRIFT_COEFF_IN,
	output logic [15:0] TEMP_RAW_IN, RTC_OFFSET_TERM_IN, RTC_SKEW_TERM_IN, RTC_STABILITY_TERM_IN,
	output logic [15:0] CHANNEL_GAIN_FACTOR_I_IN, CHANNEL_GAIN_FACTOR_V_IN, PHASE_COMP_FACTOR_IN,
	output logic [15:0] FEEDTHROUGH_COMP_FACTOR_IN
);
	task automatic drive(input logic [4:0] s, input logic [65:0] d);
		{NOMINAL_TEMP_WR_IN, COEFF_WR_IN, RTC_TERMS_WR_IN, TEMP_SAMPLE_IN, CAL_WR_IN} <= s;
		NOMINAL_TEMP_VALUE_IN <= d[15:0];
		TEMP_RAW_IN <= d[15:0];
		{LINEAR_DRIFT_COEFF_IN, QUADRATIC_DRIFT_COEFF_IN} <= d[31:0];
		{RTC_OFFSET_TERM_IN, RTC_SKEW_TERM_IN, RTC_STABILITY_TERM_IN} <= d[47:0];
		{CAL_PHASE_IN, CHANNEL_GAIN_FACTOR_I_IN, CHANNEL_GAIN_FACTOR_V_IN, PHASE_COMP_FACTOR_IN,
			FEEDTHROUGH_COMP_FACTOR_IN} <= d;
	endtask
	// select level set by host before its own coefficient writes
	task automatic mode(input logic sel, input logic [1:0] sensor);
		@(posedge CLK_IN);
		INTERNAL_COMP_SELECT_IN <= sel;
		SENSOR_TYPE_FIELD_IN <= sensor;
	endtask
	// one-cycle write strobe, data held past the strobe
	task automatic put(input int w, input logic [65:0] d);
		@(posedge CLK_IN);
		drive(5'h10 >> w, d);
		@(posedge CLK_IN);
		drive(5'h00, d);
	endtask
	initial begin
		drive(5'h00, 66'h0);
		INTERNAL_COMP_SELECT_IN <= 1'b0;
		SENSOR_TYPE_FIELD_IN <= 2'h0;
	end
endmodule

// ===== tcc_core_tb_top.sv
// Self-checking testbench for the compensation coefficient store
`timescale 1ns/1ns
module tcc_core_tb_top;
	localparam logic [15:0] LIN_REF = 16'h0123, QUAD_REF = 16'h0045, PH_DEF = 16'h0800;
	logic CLK_IN, RST_IN, INTERNAL_COMP_SELECT_IN, NOMINAL_TEMP_WR_IN, COEFF_WR_IN, TEMP_SAMPLE_IN;
	logic RTC_TERMS_WR_IN, CAL_WR_IN, COMP_ACTIVE_OUT, RTC_STEP_FWD_OUT, RTC_STEP_BACK_OUT;
	logic [1:0] SENSOR_TYPE_FIELD_IN, CAL_PHASE_IN, CAL_RD_PHASE_IN, CHANNEL_SEL_IN;
	logic [15:0] NOMINAL_TEMP_VALUE_IN, LINEAR_DRIFT_COEFF_IN, QUADRATIC_DRIFT_COEFF_IN, TEMP_RAW_IN;
	logic [15:0] RTC_OFFSET_TERM_IN, RTC_SKEW_TERM_IN, RTC_STABILITY_TERM_IN, PHASE_COMP_FACTOR_IN;
	logic [15:0] CHANNEL_GAIN_FACTOR_I_IN, CHANNEL_GAIN_FACTOR_V_IN, FEEDTHROUGH_COMP_FACTOR_IN;
	logic [15:0] NOMINAL_TEMP_VALUE_OUT, LINEAR_DRIFT_COEFF_OUT, QUADRATIC_DRIFT_COEFF_OUT;
	logic [15:0] TEMP_DELTA_OUT, CHANNEL_GAIN_FACTOR_I_OUT, CHANNEL_GAIN_FACTOR_V_OUT;
	logic [15:0] PHASE_COMP_FACTOR_OUT, FEEDTHROUGH_COMP_FACTOR_OUT;
	logic [23:0] CHANNEL_SAMPLE_IN;
	logic [39:0] SCALED_SAMPLE_OUT, fwd_n = '0, back_n = '0;
	int err_count, compares, seed = 18;
	typedef struct packed {logic [3:0] k; logic [39:0] v;} tcc_note_type;
	tcc_note_type q[$];
	tcc_note_type cur;
	wire [39:0] obs [0:11];
	assign obs = '{40'(NOMINAL_TEMP_VALUE_OUT), 40'(LINEAR_DRIFT_COEFF_OUT),
		40'(QUADRATIC_DRIFT_COEFF_OUT), 40'(COMP_ACTIVE_OUT), 40'(TEMP_DELTA_OUT),
		40'(CHANNEL_GAIN_FACTOR_I_OUT), 40'(CHANNEL_GAIN_FACTOR_V_OUT), 40'(PHASE_COMP_FACTOR_OUT),
		40'(FEEDTHROUGH_COMP_FACTOR_OUT), SCALED_SAMPLE_OUT, fwd_n, back_n};
	tcc_core #(.SECOND_CYCLES(10), .REF_LINEAR(LIN_REF), .REF_QUADRATIC(QUAD_REF),
		.PHASE_ROG_DEF(PH_DEF)) DUT (.*);
	tcc_host_model host (.*);
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic note(input logic [3:0] k, input logic [39:0] v);
		q.push_back('{k, v});
	endtask
	task automatic test_done;
		if (err_count == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		CLK_IN = 1'b0;
		forever #4 CLK_IN = ~CLK_IN;
	end
	always @(posedge CLK_IN) begin
		fwd_n <= fwd_n + 40'(RTC_STEP_FWD_OUT);
		back_n <= back_n + 40'(RTC_STEP_BACK_OUT);
	end
	always @(negedge CLK_IN) begin
		while (q.size() > 0) begin
			cur = q.pop_front();
			check(obs[cur.k], cur.v);
		end
	end
	initial begin
		#20000;
		err_count++;
		test_done;
	end
	initial begin
		logic [31:0] a;
		logic [63:0] cal [0:2];
		logic [39:0] f0, b0;
		RST_IN = 1'b1; CAL_RD_PHASE_IN = 2'h0; CHANNEL_SEL_IN = 2'h0; CHANNEL_SAMPLE_IN = 24'h0;
		repeat (5) @(posedge CLK_IN);
		RST_IN <= 1'b0;
		note(4'h0, 40'h0); note(4'h1, 40'h0); note(4'h2, 40'h0);
		note(4'h5, 40'h4000); note(4'h7, 40'h0); note(4'h8, 40'h0);
		a = $random(seed);
		host.put(1, 66'(a));
		note(4'h1, 40'h0); note(4'h2, 40'h0);
		host.mode(1'b1, 2'h0);
		host.put(0, 66'h0);
		note(4'h1, 40'(LIN_REF)); note(4'h2, 40'(QUAD_REF)); note(4'h3, 40'h0);
		host.put(0, 66'h1234);
		note(4'h1, 40'(LIN_REF)); note(4'h2, 40'(QUAD_REF)); note(4'h3, 40'h1);
		host.put(1, 66'(a));
		note(4'h1, 40'(LIN_REF));
		host.mode(1'b0, 2'h1);
		host.put(1, 66'(a));
		note(4'h1, 40'(a[31:16])); note(4'h2, 40'(a[15:0])); note(4'h7, 40'(PH_DEF));
		host.put(3, 66'h1334);
		note(4'h4, 40'h0100);
		for (int p = 0; p < 3; p++) begin
			cal[p] = {$random(seed), $random(seed)};
			host.put(4, {2'(p), cal[p]});
		end
		for (int p = 0; p < 3; p++) begin
			@(posedge CLK_IN) CAL_RD_PHASE_IN <= 2'(p);
			@(posedge CLK_IN) note(4'h5, 40'(cal[p][63:48]));
			note(4'h6, 40'(cal[p][47:32])); note(4'h7, 40'(cal[p][31:16]));
			note(4'h8, 40'(cal[p][15:0]));
		end
		host.mode(1'b0, 2'h0);
		@(posedge CLK_IN) CHANNEL_SAMPLE_IN <= 24'($random(seed));
		repeat (3) @(posedge CLK_IN);
		note(4'h8, 40'h0);
		note(4'h9, $signed({{16{CHANNEL_SAMPLE_IN[23]}}, CHANNEL_SAMPLE_IN}) *
			$signed({24'h0, cal[0][63:48]}));
		for (int s = 0; s < 2; s++) begin
			host.put(2, s ? 66'hC001 : 66'h3FFF);
			repeat (20) @(posedge CLK_IN);
			f0 = fwd_n;
			b0 = back_n;
			repeat (60) @(posedge CLK_IN);
			note(4'hA, s ? f0 : f0 + 40'h6); note(4'hB, s ? b0 + 40'h6 : b0);
		end
		repeat (2) @(posedge CLK_IN);
		test_done;
	end
endmodule
